//--- hdl/arw_pkg.sv
package arw_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] ARW_IDX_CTRLA = 8'h00;
    localparam logic [7:0] ARW_IDX_CTRLB = 8'h01;
    localparam logic [7:0] ARW_IDX_CTRLC = 8'h02;
    localparam logic [7:0] ARW_IDX_CTRLD = 8'h03;
    localparam logic [7:0] ARW_IDX_CTRLE = 8'h04;
    localparam logic [7:0] ARW_IDX_SAMPCTRL = 8'h05;
    localparam logic [7:0] ARW_IDX_MUX = 8'h06;
    localparam logic [7:0] ARW_IDX_COMMAND = 8'h08;
    localparam logic [7:0] ARW_IDX_EVCTRL = 8'h09;
    localparam logic [7:0] ARW_IDX_IRQEN = 8'h0A;
    localparam logic [7:0] ARW_IDX_FLAGS = 8'h0B;
    localparam logic [7:0] ARW_IDX_STATUS = 8'h0E;
    localparam logic [7:0] ARW_IDX_RESULT = 8'h10;
    localparam logic [7:0] ARW_IDX_WINLO = 8'h12;
    localparam logic [7:0] ARW_IDX_WINHI = 8'h14;
    // control and flag field positions
    localparam int ARW_BIT_ENABLE = 0;
    localparam int ARW_BIT_FREERUN = 1;
    localparam int ARW_BIT_RES8 = 2;
    localparam int ARW_BIT_KEEPRUN = 7;
    localparam int ARW_BIT_CAP = 6;
    localparam int ARW_POS_REF = 4;
    localparam int ARW_POS_DELAY = 5;
    localparam int ARW_BIT_READY = 0;
    localparam int ARW_BIT_WINMATCH = 1;
    // window condition codes and the reserved accumulation code
    localparam logic [2:0] ARW_WIN_OFF = 3'h0;
    localparam logic [2:0] ARW_WIN_BELOW = 3'h1;
    localparam logic [2:0] ARW_WIN_ABOVE = 3'h2;
    localparam logic [2:0] ARW_WIN_INSIDE = 3'h3;
    localparam logic [2:0] ARW_WIN_OUTSIDE = 3'h4;
    localparam logic [2:0] ARW_ACC_RESERVED = 3'h7;
    // temperature sensor channel code, arbitrary value
    localparam logic [4:0] ARW_TEMP_CHANNEL = 5'h1E;
    // peripheral clocks per initial delay step
    localparam logic [7:0] ARW_INIT_UNIT = 8'h10;
    localparam logic [15:0] ARW_RESET_WINHI = 16'h0000;

    typedef enum logic [1:0] {ARW_IDLE, ARW_DELAY, ARW_CONV} arw_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } arw_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } arw_apb_rsp_t;
endpackage : arw_pkg

//--- hdl/arw_ctrl.sv
// Contract
// - finished conversion stored in result register and result-ready flag set.
// - choosing temperature channel also switches on the temperature sensor.
// - window compare supports below, above, inside and outside, setting match flag.
// - thresholds from registers; nonzero mode enables compare and picks condition; codes 5 to 7 never match.
// - with accumulation only final sum compared; match flag once per conversion.
// - event start enable lets a router event start a conversion.
// - result-ready event pulse lasts exactly one clock per new result.
// - result-ready event always produced while enabled, regardless of irq enables.
// - each condition sets its flag even when its irq is disabled.
// - irq asserted while enable and flag both set, until flag cleared.
// - in standby no conversion starts unless keep-running bit set.
// - with keep-running, ongoing conversion completes and interrupts still raised.
// - standby starts only by event or free-run; clock requested only when busy.
// - event rising edge sets start bit; completion sets flag, clears start bit unless free-run chains the next one.
// - nonzero initial delay waited before first conversion.
// - power-down blocks starts, freezes conversion; result then marked invalid.
// - result-ready flag cleared by result read or write of one.
// - 8-bit mode drops two low bits before accumulating or storing.
// - accumulation count 0..6 selects 1,2,4..64 samples; 7 reserved.
//
// Implementation choices: the register offsets and the APB interface to the registers.
module arw_ctrl
    import arw_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire arw_apb_req_t apbReq,
    output arw_apb_rsp_t apbRsp,
    input wire logic eventIn,
    input wire logic sleepStandby,
    input wire logic sleepPowerDown,
    input wire logic adcDone,
    input wire logic [9:0] adcCode,
    output logic adcStart,
    output logic adcHold,
    output logic [4:0] positiveInputSelect,
    output logic [1:0] referenceSelect,
    output logic sampleCapSelect,
    output logic [2:0] prescaleSelect,
    output logic [3:0] sampleDelay,
    output logic [4:0] sampleLength,
    output logic tempSensorOn,
    output logic resultReadyEvent,
    output logic clockRequest,
    output logic irq
);

    typedef struct packed {
        arw_state_t state;
        arw_apb_rsp_t rsp;
        logic enable;
        logic freeRun;
        logic resolution8;
        logic standbyKeepRunning;
        logic [2:0] accumulationCount;
        logic sampleCap;
        logic [1:0] reference_select;
        logic [2:0] presc;
        logic [2:0] initialDelay;
        logic [3:0] sampDly;
        logic [2:0] windowConditionSelect;
        logic [4:0] sampleLen;
        logic [4:0] positive_input_select;
        logic startConversion;
        logic eventStartEnable;
        logic [1:0] irqEnable;
        logic [1:0] flags;
        logic [15:0] conversionResult;
        logic [15:0] windowLowThreshold;
        logic [15:0] windowHighThreshold;
        logic [15:0] accum;
        logic [6:0] sampleCnt;
        logic [7:0] delayCnt;
        logic firstConv;
        logic halted;
        logic resultInvalid;
        logic eventPrev;
        logic startPulse;
        logic holdOut;
        logic resEvent;
        logic clkReq;
        logic tempOn;
        logic irqOut;
    } arw_regs_t;

    arw_regs_t r;
    arw_regs_t n;

    // next-state logic for registers, sequencer and bus answer
    always_comb begin
        logic [7:0] idx;
        logic mapped;
        logic wrAcc;
        logic rdAcc;
        logic evRise;
        logic runOk;
        logic [9:0] sample;
        logic [15:0] sum;
        logic [6:0] target;
        logic finish;
        logic match;
        logic [1:0] setFlags;
        logic [1:0] clrFlags;
        logic [31:0] rdata;
        // word index from the byte address
        idx = apbReq.paddr[9:2];
        mapped = 1'b0;
        wrAcc = 1'b0;
        rdAcc = 1'b0;
        evRise = 1'b0;
        runOk = 1'b0;
        sample = 10'h000;
        sum = 16'h0000;
        target = 7'h01;
        finish = 1'b0;
        match = 1'b0;
        setFlags = 2'h0;
        clrFlags = 2'h0;
        rdata = 32'h0000_0000;
        // state holds unless a branch below changes it; pulses fall
        n = r;
        n.startPulse = 1'b0;
        n.resEvent = 1'b0;

        // address decode and read data, prepared in the setup cycle
        unique case (idx)
            ARW_IDX_CTRLA: rdata = {24'h0, r.standbyKeepRunning, 4'h0, r.resolution8,
                                    r.freeRun, r.enable};
            ARW_IDX_CTRLB: rdata = {29'h0, r.accumulationCount};
            ARW_IDX_CTRLC: rdata = {25'h0, r.sampleCap, r.reference_select, 1'b0, r.presc};
            ARW_IDX_CTRLD: rdata = {24'h0, r.initialDelay, 1'b0, r.sampDly};
            ARW_IDX_CTRLE: rdata = {29'h0, r.windowConditionSelect};
            ARW_IDX_SAMPCTRL: rdata = {27'h0, r.sampleLen};
            ARW_IDX_MUX: rdata = {27'h0, r.positive_input_select};
            ARW_IDX_COMMAND: rdata = {31'h0, r.startConversion};
            ARW_IDX_EVCTRL: rdata = {31'h0, r.eventStartEnable};
            ARW_IDX_IRQEN: rdata = {30'h0, r.irqEnable};
            ARW_IDX_FLAGS: rdata = {30'h0, r.flags};
            ARW_IDX_STATUS: rdata = {29'h0, r.clkReq, r.resultInvalid, r.halted};
            ARW_IDX_RESULT: rdata = {16'h0, r.conversionResult};
            ARW_IDX_WINLO: rdata = {16'h0, r.windowLowThreshold};
            ARW_IDX_WINHI: rdata = {16'h0, r.windowHighThreshold};
            default: rdata = 32'h0000_0000;
        endcase
        unique case (idx)
            ARW_IDX_CTRLA, ARW_IDX_CTRLB, ARW_IDX_CTRLC, ARW_IDX_CTRLD,
            ARW_IDX_CTRLE, ARW_IDX_SAMPCTRL, ARW_IDX_MUX, ARW_IDX_COMMAND,
            ARW_IDX_EVCTRL, ARW_IDX_IRQEN, ARW_IDX_FLAGS, ARW_IDX_STATUS,
            ARW_IDX_RESULT, ARW_IDX_WINLO, ARW_IDX_WINHI: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
        mapped = mapped & (apbReq.paddr[11:10] == 2'h0) & (apbReq.paddr[1:0] == 2'h0);

        // no wait state: answer registered in setup, completes in the first access cycle
        n.rsp.pready = apbReq.psel & ~apbReq.penable;
        n.rsp.pslverr = apbReq.psel & ~apbReq.penable & ~mapped;
        if (apbReq.psel && !apbReq.penable) begin
            n.rsp.prdata = apbReq.pwrite ? 32'h0000_0000 : rdata;
        end
        // effects happen only at the completing access edge
        wrAcc = apbReq.psel & apbReq.penable & r.rsp.pready & apbReq.pwrite & mapped;
        rdAcc = apbReq.psel & apbReq.penable & r.rsp.pready & ~apbReq.pwrite & mapped;

        // register writes
        if (wrAcc) begin
            unique case (idx)
                ARW_IDX_CTRLA: begin
                    n.enable = apbReq.pwdata[ARW_BIT_ENABLE];
                    n.freeRun = apbReq.pwdata[ARW_BIT_FREERUN];
                    n.resolution8 = apbReq.pwdata[ARW_BIT_RES8];
                    n.standbyKeepRunning = apbReq.pwdata[ARW_BIT_KEEPRUN];
                end
                ARW_IDX_CTRLB: n.accumulationCount = apbReq.pwdata[2:0];
                ARW_IDX_CTRLC: begin
                    n.sampleCap = apbReq.pwdata[ARW_BIT_CAP];
                    n.reference_select = apbReq.pwdata[ARW_POS_REF +: 2];
                    n.presc = apbReq.pwdata[2:0];
                end
                ARW_IDX_CTRLD: begin
                    n.initialDelay = apbReq.pwdata[ARW_POS_DELAY +: 3];
                    n.sampDly = apbReq.pwdata[3:0];
                end
                ARW_IDX_CTRLE: n.windowConditionSelect = apbReq.pwdata[2:0];
                ARW_IDX_SAMPCTRL: n.sampleLen = apbReq.pwdata[4:0];
                ARW_IDX_MUX: n.positive_input_select = apbReq.pwdata[4:0];
                ARW_IDX_EVCTRL: n.eventStartEnable = apbReq.pwdata[0];
                ARW_IDX_IRQEN: n.irqEnable = apbReq.pwdata[1:0];
                ARW_IDX_FLAGS: clrFlags = apbReq.pwdata[1:0];
                ARW_IDX_WINLO: n.windowLowThreshold = apbReq.pwdata[15:0];
                ARW_IDX_WINHI: n.windowHighThreshold = apbReq.pwdata[15:0];
                default: n.enable = r.enable;
            endcase
        end
        // reading the result clears its ready flag
        if (rdAcc && idx == ARW_IDX_RESULT) begin
            clrFlags[ARW_BIT_READY] = 1'b1;
        end

        // converter may run while enabled, unless in power-down or in standby without keep-running
        runOk = r.enable & ~sleepPowerDown & ~(sleepStandby & ~r.standbyKeepRunning);
        // edge detector idles low like its pin, so no edge after reset
        evRise = eventIn & ~r.eventPrev;
        n.eventPrev = eventIn;

        // samples per conversion, reserved code treated as one sample
        if (r.accumulationCount == ARW_ACC_RESERVED) begin
            target = 7'h01;
        end else begin
            target = 7'(7'h01 << r.accumulationCount);
        end
        // 8-bit mode keeps the upper eight bits of the code
        sample = r.resolution8 ? {2'h0, adcCode[9:2]} : adcCode;
        // running sum of the samples taken so far
        sum = r.accum + {6'h00, sample};

        // conversion sequencer
        unique case (r.state)
            ARW_IDLE: begin
                if (r.startConversion && runOk) begin
                    if (r.firstConv && r.initialDelay != 3'h0) begin
                        n.state = ARW_DELAY;
                        n.delayCnt = 8'(r.initialDelay * ARW_INIT_UNIT);
                    end else begin
                        n.state = ARW_CONV;
                        n.startPulse = 1'b1;
                    end
                    // later starts skip the initial delay
                    n.firstConv = 1'b0;
                    n.accum = 16'h0000;
                    n.sampleCnt = 7'h00;
                end
            end
            ARW_DELAY: begin
                if (!r.enable) begin
                    n.state = ARW_IDLE;
                end else if (!runOk) begin
                    n.delayCnt = r.delayCnt;
                end else if (r.delayCnt <= 8'h01) begin
                    n.state = ARW_CONV;
                    n.startPulse = 1'b1;
                end else begin
                    n.delayCnt = r.delayCnt - 8'h01;
                end
            end
            ARW_CONV: begin
                if (!r.enable) begin
                    n.state = ARW_IDLE;
                end else if (sleepPowerDown) begin
                    n.halted = 1'b1;
                end else if (adcDone) begin
                    finish = (r.sampleCnt == target - 7'h01);
                    if (finish) begin
                        // only the final sum is stored and compared
                        n.conversionResult = sum;
                        n.resultInvalid = r.halted;
                        n.halted = 1'b0;
                        n.accum = 16'h0000;
                        n.sampleCnt = 7'h00;
                        n.resEvent = 1'b1;
                        setFlags[ARW_BIT_READY] = 1'b1;
                        // free-run chains the next conversion at once
                        if (r.freeRun && runOk) begin
                            n.startPulse = 1'b1;
                        end else begin
                            n.state = ARW_IDLE;
                            n.startConversion = 1'b0;
                        end
                    end else begin
                        n.accum = sum;
                        n.sampleCnt = r.sampleCnt + 7'h01;
                        n.startPulse = 1'b1;
                    end
                end
            end
            default: n.state = ARW_IDLE;
        endcase

        // window compare on the value being written
        unique case (r.windowConditionSelect)
            ARW_WIN_BELOW: match = sum < r.windowLowThreshold;
            ARW_WIN_ABOVE: match = sum > r.windowHighThreshold;
            ARW_WIN_INSIDE: match = (sum > r.windowLowThreshold) &&
                                    (sum < r.windowHighThreshold);
            ARW_WIN_OUTSIDE: match = (sum < r.windowLowThreshold) ||
                                     (sum > r.windowHighThreshold);
            default: match = 1'b0;
        endcase
        setFlags[ARW_BIT_WINMATCH] = finish & match;

        // start bit: software write or enabled event edge sets it
        if (wrAcc && idx == ARW_IDX_COMMAND && apbReq.pwdata[0]) begin
            n.startConversion = 1'b1;
        end
        if (evRise && r.eventStartEnable && r.enable) begin
            n.startConversion = 1'b1;
        end
        // leaving enable or entering standby rearms the initial delay
        if (!r.enable || (sleepStandby && r.state == ARW_IDLE)) begin
            n.firstConv = 1'b1;
        end
        // disabling drops a pending start
        if (!r.enable) begin
            n.startConversion = 1'b0;
        end

        // flags: a set in the same cycle wins over a clear
        n.flags = (r.flags & ~clrFlags) | setFlags;
        n.irqOut = |(n.flags & n.irqEnable);
        // registered copies for the output pins
        n.holdOut = (n.state == ARW_CONV) & sleepPowerDown;
        n.clkReq = (n.state != ARW_IDLE) | n.startConversion & runOk;
        n.tempOn = (n.positive_input_select == ARW_TEMP_CHANNEL);
    end

    // single state register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
            r.state <= ARW_IDLE;
            r.windowHighThreshold <= ARW_RESET_WINHI;
            r.firstConv <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // outputs straight from the state register
    assign apbRsp = r.rsp;
    assign adcStart = r.startPulse;
    assign adcHold = r.holdOut;
    assign positiveInputSelect = r.positive_input_select;
    assign referenceSelect = r.reference_select;
    assign sampleCapSelect = r.sampleCap;
    assign prescaleSelect = r.presc;
    assign sampleDelay = r.sampDly;
    assign sampleLength = r.sampleLen;
    assign tempSensorOn = r.tempOn;
    assign resultReadyEvent = r.resEvent;
    assign clockRequest = r.clkReq;
    assign irq = r.irqOut;

endmodule : arw_ctrl

//--- tb/arw_ctrl_assertions.sv
module arw_ctrl_assertions
    import arw_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire arw_apb_req_t apbReq,
    input wire arw_apb_rsp_t apbRsp,
    input wire logic sleepPowerDown,
    input wire logic adcDone,
    input wire logic adcStart,
    input wire logic adcHold,
    input wire logic [4:0] positiveInputSelect,
    input wire logic tempSensorOn,
    input wire logic resultReadyEvent,
    input wire logic clockRequest,
    input wire logic irq
);
    logic apbAcc;
    // a completed bus access, the only way software clears a flag
    assign apbAcc = apbReq.psel && apbReq.penable && apbRsp.pready;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    property p_rre_pulse; resultReadyEvent |=> !resultReadyEvent; endproperty
    property p_rre_cause; resultReadyEvent |-> $past(adcDone); endproperty
    property p_irq_hold; irq && !apbAcc && !$past(apbAcc) |=> irq; endproperty
    property p_pd_nostart; sleepPowerDown ##1 sleepPowerDown |-> !adcStart; endproperty
    property p_hold_cause; adcHold |-> $past(sleepPowerDown); endproperty
    property p_temp; tempSensorOn == (positiveInputSelect == ARW_TEMP_CHANNEL); endproperty
    property p_apb_ready; apbReq.psel && !apbReq.penable |=> apbRsp.pready; endproperty
    property p_start_clk; adcStart |-> clockRequest; endproperty
    property p_start_pulse; adcStart |=> !adcStart; endproperty
    a_rre_pulse: assert property (p_rre_pulse) else $error("result event too long");
    a_rre_cause: assert property (p_rre_cause) else $error("event without sample");
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped early");
    a_pd_nostart: assert property (p_pd_nostart) else $error("start in power-down");
    a_hold_cause: assert property (p_hold_cause) else $error("hold without sleep");
    a_temp: assert property (p_temp) else $error("sensor enable wrong");
    a_apb_ready: assert property (p_apb_ready) else $error("no ready after setup");
    a_start_clk: assert property (p_start_clk) else $error("start without clock");
    a_start_pulse: assert property (p_start_pulse) else $error("start too long");
    c_rre: cover property (resultReadyEvent);
    c_irq: cover property ($rose(irq));
    c_hold: cover property (adcHold);
endmodule : arw_ctrl_assertions

bind arw_ctrl arw_ctrl_assertions chk_u (.core_clk, .rstn, .apbReq, .apbRsp, .sleepPowerDown,
    .adcDone, .adcStart, .adcHold, .positiveInputSelect, .tempSensorOn, .resultReadyEvent,
    .clockRequest, .irq);

//--- tb/arw_adc_model.sv
module arw_adc_model #(
    parameter int LAT = 6
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic adcStart,
    input wire logic adcHold,
    input wire logic [9:0] codeIn,
    output logic adcDone,
    output logic [9:0] adcCode
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    logic busy;
    logic [9:0] last;
    // code is only valid with done; otherwise the inverse is shown
    assign adcCode = adcDone ? last : ~last;
    // sample timer, frozen while held
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 0;
            busy <= 1'b0;
            adcDone <= 1'b0;
            last <= 10'h000;
        end else begin
            adcDone <= 1'b0;
            if (adcStart) begin
                busy <= 1'b1;
                cnt <= LAT;
            end else if (busy && !adcHold) begin
                if (cnt == 0) begin
                    busy <= 1'b0;
                    adcDone <= 1'b1;
                    last <= codeIn;
                end else begin
                    cnt <= cnt - 1;
                end
            end
        end
    end
endmodule : arw_adc_model

//--- tb/arw_ctrl_tb_top.sv
module arw_ctrl_tb_top
    import arw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    arw_apb_req_t req = '0;
    arw_apb_rsp_t rsp;
    logic eventIn = 1'b0;
    logic sleepStandby = 1'b0;
    logic sleepPowerDown = 1'b0;
    logic adcDone, adcStart, adcHold, tempSensorOn, rre, clockRequest, irq, slv;
    logic [9:0] adcCode;
    logic [9:0] adcValue = 10'h000;
    logic [4:0] posSel;
    logic [31:0] rdat;
    logic [9:0] codes [5] = '{10'h100, 10'h150, 10'h200, 10'h050, 10'h300};
    int errCount = 0;
    int nCompared = 0;
    int n;

    arw_ctrl dut_u (.core_clk, .rstn, .apbReq(req), .apbRsp(rsp), .eventIn, .sleepStandby,
        .sleepPowerDown, .adcDone, .adcCode, .adcStart, .adcHold, .positiveInputSelect(posSel),
        .referenceSelect(), .sampleCapSelect(), .prescaleSelect(), .sampleDelay(),
        .sampleLength(), .tempSensorOn, .resultReadyEvent(rre), .clockRequest, .irq);
    arw_adc_model adc_u (.core_clk, .rstn, .adcStart, .adcHold, .codeIn(adcValue), .adcDone,
        .adcCode);

    // free-running 125 MHz clock
    initial begin
        forever #4 core_clk = ~core_clk;
    end

    task summarize;
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    task check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
            errCount++;
        end
    endtask : check

    task fail;
        errCount++;
        summarize;
    endtask : fail

    // one bus transfer; read data and error taken at the ready edge
    task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int i;
        @(posedge core_clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'b00, idx, 2'b00}, pwdata: wd};
        @(posedge core_clk);
        req.penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (rsp.pready === 1'b1) break;
        end
        if (i == 20) fail;
        rdat = rsp.prdata;
        slv = rsp.pslverr;
        req <= '0;
    endtask : apb

    task wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask : wr

    task rd(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        check(rdat, exp);
    endtask : rd

    task wait_rre;
        int i;
        for (i = 0; i < 1000; i++) begin
            @(posedge core_clk);
            #1;
            if (rre === 1'b1) break;
        end
        if (i == 1000) fail;
    endtask : wait_rre

    // count result events over a fixed span
    task quiet(input int cyc);
        n = 0;
        repeat (cyc) begin
            @(posedge core_clk);
            #1;
            if (rre === 1'b1) n++;
        end
    endtask : quiet

    task convert(input logic [9:0] code);
        @(posedge core_clk);
        adcValue <= code;
        wr(ARW_IDX_COMMAND, 32'h1);
        wait_rre;
    endtask : convert

    function logic win_exp(input logic [2:0] md, input logic [15:0] v);
        case (md)
            ARW_WIN_BELOW: return v < 16'h0100;
            ARW_WIN_ABOVE: return v > 16'h0200;
            ARW_WIN_INSIDE: return v > 16'h0100 && v < 16'h0200;
            ARW_WIN_OUTSIDE: return v < 16'h0100 || v > 16'h0200;
            default: return 1'b0;
        endcase
    endfunction : win_exp

    task s_reset;
        rd(ARW_IDX_CTRLA, 32'h0);
        rd(ARW_IDX_FLAGS, 32'h0);
        rd(ARW_IDX_WINHI, {16'h0000, ARW_RESET_WINHI});
        apb(1'b0, 8'h07, 32'h0);
        check(slv, 1'b1);
        check(rdat, 32'h0);
    endtask : s_reset

    task s_initial_delay;
        wr(ARW_IDX_CTRLD, 32'h20);
        wr(ARW_IDX_CTRLA, 32'h1);
        wr(ARW_IDX_COMMAND, 32'h1);
        n = 0;
        while (adcStart !== 1'b1 && n < 200) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n == 200) fail;
        check(n >= 16, 1'b1);
        wait_rre;
        wr(ARW_IDX_CTRLD, 32'h0);
        rd(ARW_IDX_RESULT, 32'h0);
    endtask : s_initial_delay

    task s_single;
        @(posedge core_clk);
        adcValue <= 10'h2A5;
        wr(ARW_IDX_COMMAND, 32'h1);
        rd(ARW_IDX_COMMAND, 32'h1);
        wait_rre;
        check(irq, 1'b0);
        rd(ARW_IDX_FLAGS, 32'h1);
        rd(ARW_IDX_RESULT, 32'h2A5);
        rd(ARW_IDX_FLAGS, 32'h0);
        rd(ARW_IDX_COMMAND, 32'h0);
    endtask : s_single

    task s_irq;
        wr(ARW_IDX_IRQEN, 32'h1);
        convert(10'h011);
        repeat (3) @(posedge core_clk);
        check(irq, 1'b1);
        wr(ARW_IDX_FLAGS, 32'h1);
        repeat (2) @(posedge core_clk);
        check(irq, 1'b0);
        wr(ARW_IDX_IRQEN, 32'h0);
    endtask : s_irq

    task s_accum;
        wr(ARW_IDX_CTRLA, 32'h5);
        convert(10'h3FF);
        rd(ARW_IDX_RESULT, 32'hFF);
        wr(ARW_IDX_CTRLA, 32'h1);
        wr(ARW_IDX_WINLO, 32'h800);
        wr(ARW_IDX_CTRLE, {29'h0, ARW_WIN_BELOW});
        wr(ARW_IDX_CTRLB, 32'h2);
        convert(10'h3FF);
        rd(ARW_IDX_RESULT, 32'hFFC);
        rd(ARW_IDX_FLAGS, 32'h0);
        wr(ARW_IDX_CTRLE, 32'h0);
        wr(ARW_IDX_CTRLB, {29'h0, ARW_ACC_RESERVED});
        convert(10'h123);
        rd(ARW_IDX_RESULT, 32'h123);
        wr(ARW_IDX_CTRLB, 32'h6);
        convert(10'h3FF);
        rd(ARW_IDX_RESULT, 32'hFFC0);
        wr(ARW_IDX_CTRLB, 32'h0);
    endtask : s_accum

    task s_window;
        wr(ARW_IDX_WINLO, 32'h100);
        wr(ARW_IDX_WINHI, 32'h200);
        for (int m = 0; m < 5; m++) begin
            wr(ARW_IDX_CTRLE, 32'(m));
            for (int k = 0; k < 5; k++) begin
                convert(codes[k]);
                rd(ARW_IDX_RESULT, {22'h0, codes[k]});
                rd(ARW_IDX_FLAGS, {30'h0, win_exp(3'(m), {6'h0, codes[k]}), 1'b0});
                wr(ARW_IDX_FLAGS, 32'h3);
            end
        end
        wr(ARW_IDX_CTRLE, 32'h0);
    endtask : s_window

    task s_event;
        wr(ARW_IDX_EVCTRL, 32'h1);
        @(posedge core_clk);
        adcValue <= 10'h0AA;
        eventIn <= 1'b1;
        wait_rre;
        rd(ARW_IDX_RESULT, 32'hAA);
        rd(ARW_IDX_COMMAND, 32'h0);
        eventIn <= 1'b0;
        wr(ARW_IDX_EVCTRL, 32'h0);
        eventIn <= 1'b1;
        quiet(60);
        check(n, 0);
        eventIn <= 1'b0;
    endtask : s_event

    task s_temp;
        wr(ARW_IDX_CTRLC, 32'h40);
        wr(ARW_IDX_MUX, {27'h0, ARW_TEMP_CHANNEL});
        repeat (2) @(posedge core_clk);
        check(tempSensorOn, 1'b1);
        wr(ARW_IDX_MUX, 32'h0);
        repeat (2) @(posedge core_clk);
        check(tempSensorOn, 1'b0);
    endtask : s_temp

    task s_pd;
        @(posedge core_clk);
        adcValue <= 10'h155;
        wr(ARW_IDX_COMMAND, 32'h1);
        // sleep only once the first sample is under way
        repeat (2) @(posedge core_clk);
        sleepPowerDown <= 1'b1;
        quiet(30);
        check(n, 0);
        check(adcHold, 1'b1);
        @(posedge core_clk);
        sleepPowerDown <= 1'b0;
        wait_rre;
        rd(ARW_IDX_FLAGS, 32'h1);
        apb(1'b0, ARW_IDX_STATUS, 32'h0);
        check(rdat[1], 1'b1);
        apb(1'b0, ARW_IDX_RESULT, 32'h0);
    endtask : s_pd

    task s_standby;
        wr(ARW_IDX_CTRLA, 32'h81);
        wr(ARW_IDX_EVCTRL, 32'h1);
        adcValue <= 10'h3C3;
        sleepStandby <= 1'b1;
        eventIn <= 1'b1;
        wait_rre;
        rd(ARW_IDX_RESULT, 32'h3C3);
        check(clockRequest, 1'b0);
        eventIn <= 1'b0;
        wr(ARW_IDX_CTRLA, 32'h1);
        eventIn <= 1'b1;
        quiet(60);
        check(n, 0);
    endtask : s_standby

    // main sequence
    initial begin
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        s_reset;
        s_initial_delay;
        s_single;
        s_irq;
        s_accum;
        s_window;
        s_event;
        s_temp;
        s_pd;
        s_standby;
        summarize;
    end
endmodule : arw_ctrl_tb_top
